// [gpm_port.sv]
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module gpm_port
    import gpm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    // Pins
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe_n,
    // Peripheral enables and settings
    input  wire logic        timer_osc_enable,
    input  wire logic        capture_two_pin_assign,
    input  wire logic        capture_one_enable,
    input  wire logic        capture_two_enable,
    input  wire logic [1:0]  serial_mode,
    input  wire logic        twi_smbus_levels,
    input  wire logic        transceiver_enable,
    input  wire logic        transceiver_sync,
    input  wire logic        transceiver_sync_master,
    input  wire logic        transceiver_sync_tx,
    input  wire logic        twi_scl_drive_low,
    input  wire logic        twi_sda_drive_low,
    // Peripheral output data
    input  wire logic        capture_one_out,
    input  wire logic        capture_two_out,
    input  wire logic        spi_clock_out,
    input  wire logic        spi_data_out,
    input  wire logic        transceiver_transmit_out,
    input  wire logic        transceiver_sync_data_out,
    // Peripheral input data
    output logic             timer_counter_clock_in,
    output logic             capture_one_in,
    output logic             capture_two_in,
    output logic             serial_clock_in,
    output logic             serial_data_in,
    output logic             transceiver_receive_in,
    output logic             transceiver_sync_clock,
    output logic             twi_smbus_threshold,
    output logic             capture_two_on_port
);

    // Structure in brief:
    // - software registers live in one comb/ff pair
    // - the bus answers one cycle after it sees a request
    // - the pin mux starts from the plain port path and
    //   lets each enabled peripheral take its pins in turn
    // - every output leaves through a flip-flop, so pin and
    //   peripheral paths lag their cause by one clock, and
    //   pin reads lag the pins themselves by three
    // Peripheral overrides never write the direction or
    // latch registers; they only steer the pin drive. This
    // keeps register reads honest while a peripheral owns
    // a pin, at the cost of a separate drive register.
    // The channel-two routing strap is sampled into a
    // flip-flop so the routing flag leaves from a register
    // like every other output.

    // Register state
    logic [7:0]  dir_q, dir_d;            // port_direction
    logic [7:0]  lat_q, lat_d;            // port_output_latch
    logic [7:0]  olat_q, olat_d;          // other_port_latch_with_open_drain
    logic [7:0]  odir_q, odir_d;          // other_port_direction_with_open_drain
    logic [31:0] rdata_q, rdata_d;
    logic        wait_q, wait_d;          // Low for one cycle to answer
    logic [1:0]  resp_q, resp_d;
    // Pin synchronisers
    logic [7:0]  sync1_q, sync2_q;
    // Pin drive registers
    logic [7:0]  out_q, out_d, oen_q, oen_d;
    // Peripheral input registers
    logic [8:0]  pin_fn_q, pin_fn_d;
    // Routing strap copy
    logic        capture_two_pin_assign_q;

    gpm_ser_mode_e ser_mode;              // Decoded serial mode
    logic          acc;                   // Request in progress
    logic          hit;                   // Address maps to a register

    // Only lane zero carries data: the registers are a
    // byte wide, so the upper lanes are ignored on write
    // and read back as zero. A write with lane zero off
    // leaves the register unchanged but is still answered,
    // so the master never waits on a partial write.
    // Merge byte lane zero into an 8-bit register
    function automatic logic [7:0] gpm_merge(input logic [7:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        gpm_merge = be[0] ? wd[7:0] : old;
    endfunction

    // Codes outside the two known modes fall back to off,
    // so a stray setting leaves pins 3 to 5 under the
    // plain port path rather than half claimed.
    // Serial mode decode
    always_comb begin
        case (serial_mode)
            2'h1:    ser_mode = GPM_SER_SPI;
            2'h2:    ser_mode = GPM_SER_TWI;
            default: ser_mode = GPM_SER_OFF;
        endcase
    end

    // A request is taken only while waitrequest is high,
    // so the cycle that shows the answer cannot start a
    // second access from the same, still held, request.
    // Decode accepts the five aligned offsets only.
    // Bus access decode; answer comes one cycle after request seen
    always_comb begin
        acc = (avs_read | avs_write) & wait_q;
        hit = (avs_address[4:2] <= 3'h4) & (avs_address[1:0] == 2'h0);
    end

    // Writes and reads share one decode. Unmapped or
    // misaligned addresses get a slave-error response and
    // zero data, and no register is touched. Read data and
    // response stand until the next answer replaces them.
    // A register changes at the edge that takes the
    // request, one edge before the master sees waitrequest
    // low; no other access can fall in between, because
    // the master still holds its request then.
    // The unimplemented bit of the other latch is masked
    // on write so it always reads back as zero.
    // Register next-state and bus answer
    always_comb begin
        dir_d   = dir_q;
        lat_d   = lat_q;
        olat_d  = olat_q;
        odir_d  = odir_q;
        rdata_d = rdata_q;
        resp_d  = resp_q;
        wait_d  = 1'b1;
        if (acc) begin
            // Answer now; waitrequest drops for exactly this cycle's edge
            wait_d = 1'b0;
            resp_d = hit ? 2'h0 : 2'h2;  // Unmapped gives slave error
            rdata_d = 32'h0;
            if (avs_write && hit) begin
                case ({1'b0, avs_address[4:0]})
                    {1'b0, 1'b0, GPM_OFS_PIN_LEVELS},
                    {1'b0, 1'b0, GPM_OFS_OUT_LATCH}:  lat_d = gpm_merge(lat_q, avs_writedata, avs_byteenable);
                    {1'b0, 1'b0, GPM_OFS_DIRECTION}:  dir_d = gpm_merge(dir_q, avs_writedata, avs_byteenable);
                    {1'b0, 1'b0, GPM_OFS_OTHER_LATCH}:
                        olat_d = gpm_merge(olat_q, avs_writedata, avs_byteenable) & GPM_OTHER_LATCH_MASK;
                    {1'b0, GPM_OFS_OTHER_DIR_B}:     odir_d = gpm_merge(odir_q, avs_writedata, avs_byteenable);
                    default: ;
                endcase
            end else if (avs_read && hit) begin
                case ({1'b0, avs_address[4:0]})
                    {1'b0, 1'b0, GPM_OFS_PIN_LEVELS}:  rdata_d = {24'h0, pin_fn_q[7:0]};
                    {1'b0, 1'b0, GPM_OFS_OUT_LATCH}:   rdata_d = {24'h0, lat_q};
                    {1'b0, 1'b0, GPM_OFS_DIRECTION}:   rdata_d = {24'h0, dir_q};
                    {1'b0, 1'b0, GPM_OFS_OTHER_LATCH}: rdata_d = {24'h0, olat_q};
                    {1'b0, GPM_OFS_OTHER_DIR_B}:      rdata_d = {24'h0, odir_q};
                    default:                          rdata_d = 32'h0;
                endcase
            end
        end
    end

    // Priority, lowest first: plain port, then timer
    // oscillator on pins 0 and 1 or channel two on pin 1, channel
    // one on pin 2, serial module on pins 3 to 5, and the
    // transceiver on pins 6 and 7. Open-drain is applied
    // last, so it can only release a pin, never drive one
    // that an earlier stage left as an input.
    // Open-drain selects are read only inside the branch
    // of an active peripheral, so a select left set has
    // no effect once its peripheral is turned off.
    // Pin multiplexing: peripheral override, then plain port
    always_comb begin
        logic [7:0] drv;   // Pin is an output
        logic [7:0] val;   // Value to drive
        logic [7:0] od;    // Open-drain applies
        logic       cap2;  // Channel two lives on pin one
        drv  = ~dir_q;     // Plain port: 0 drives latch
        val  = lat_q;
        od   = 8'h00;
        cap2 = capture_two_pin_assign & capture_two_enable;
        // The oscillator wins over channel two: both want
        // pin 1, and a driven pin would stall the crystal.
        // Timer oscillator owns pins 0 and 1, digital off regardless of direction
        if (timer_osc_enable) begin
            drv[GPM_PIN_OSC_OUT] = 1'b0;
            drv[GPM_PIN_OSC_IN]  = 1'b0;
        end else if (cap2 && !dir_q[GPM_PIN_OSC_IN]) begin
            val[GPM_PIN_OSC_IN] = capture_two_out;
            od[GPM_PIN_OSC_IN]  = odir_q[GPM_BIT_CAP2_OD];
        end
        // Channel one only replaces the value; the
        // direction bit still decides drive or capture
        if (capture_one_enable && !dir_q[GPM_PIN_CAP1]) begin
            val[GPM_PIN_CAP1] = capture_one_out;
            od[GPM_PIN_CAP1]  = odir_q[GPM_BIT_CAP1_OD];
        end
        // Serial module: SPI follows the direction bits,
        // two-wire takes the direction over completely
        case (ser_mode)
            GPM_SER_SPI: begin
                if (!dir_q[GPM_PIN_SCK]) begin
                    val[GPM_PIN_SCK] = spi_clock_out;
                    od[GPM_PIN_SCK]  = odir_q[GPM_BIT_SPI_OD];
                end
                if (!dir_q[GPM_PIN_SDO]) begin
                    val[GPM_PIN_SDO] = spi_data_out;
                    od[GPM_PIN_SDO]  = odir_q[GPM_BIT_SPI_OD];
                end
            end
            GPM_SER_TWI: begin
                // Two-wire lines pull low only, released otherwise
                drv[GPM_PIN_SCK] = twi_scl_drive_low;
                val[GPM_PIN_SCK] = 1'b0;
                drv[GPM_PIN_SDI] = twi_sda_drive_low;
                val[GPM_PIN_SDI] = 1'b0;
            end
            default: ;
        endcase
        // Transceiver: asynchronous mode forces transmit
        // out and receive in; synchronous mode lets the
        // transceiver pick the drive of both pins
        if (transceiver_enable) begin
            if (!transceiver_sync) begin
                drv[GPM_PIN_TX] = 1'b1;
                val[GPM_PIN_TX] = transceiver_transmit_out;
                drv[GPM_PIN_RX] = 1'b0;
            end else begin
                drv[GPM_PIN_TX] = transceiver_sync_master;
                val[GPM_PIN_TX] = transceiver_transmit_out;
                // Receive pin drive follows transceiver_sync_tx, whatever the direction bit
                drv[GPM_PIN_RX] = transceiver_sync_tx;
                val[GPM_PIN_RX] = transceiver_sync_data_out;
            end
            od[GPM_PIN_TX] = olat_q[GPM_BIT_SER_OD];
            od[GPM_PIN_RX] = olat_q[GPM_BIT_SER_OD] & transceiver_sync;
        end
        // A high value on an open-drain pin is a release,
        // left to the board's pull-up to bring the line up
        // Open-drain: drive only the low level
        for (int i = 0; i < GPM_W; i++) begin
            if (od[i] && val[i]) begin
                drv[i] = 1'b0;
            end
        end
        out_d = val;
        oen_d = ~drv; // Disabled peripherals fall back to plain path
        // Every peripheral input sees the synchronised pin,
        // never the raw one, so no metastable level leaks in
        // Peripheral inputs from synchronised pins
        pin_fn_d       = {1'b0, sync2_q};
        pin_fn_d[8]    = twi_smbus_levels & (ser_mode == GPM_SER_TWI);
    end

    // Reset is synchronous and loads constants only.
    // Pins come up as inputs and the bus comes up busy
    // until the first request, so only the transceiver and
    // two-wire paths can drive the board before software
    // has set a direction.
    // Register update; reset returns all pins to input
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dir_q    <= GPM_RST_DIRECTION;
            lat_q    <= GPM_RST_LATCH;
            olat_q   <= GPM_RST_OTHER;
            odir_q   <= GPM_RST_OTHER;
            rdata_q  <= 32'h0;
            wait_q   <= 1'b1;
            resp_q   <= 2'h0;
            sync1_q  <= 8'h00;
            sync2_q  <= 8'h00;
            out_q    <= 8'h00;
            oen_q    <= 8'hFF;
            pin_fn_q <= 9'h000;
        end else begin
            dir_q    <= dir_d;
            lat_q    <= lat_d;
            olat_q   <= olat_d;
            odir_q   <= odir_d;
            rdata_q  <= rdata_d;
            wait_q   <= wait_d;
            resp_q   <= resp_d;
            sync1_q  <= pin_in;             // Only read by second stage
            sync2_q  <= sync1_q;
            out_q    <= out_d;
            oen_q    <= oen_d;
            pin_fn_q <= pin_fn_d;
        end
    end

    // Plain wiring of registered values to the ports; no
    // logic here, so every output has a clean timing
    // start point at a flip-flop.
    // Outputs straight from flip-flops
    always_comb begin
        avs_readdata           = rdata_q;
        avs_waitrequest        = wait_q;
        avs_response           = resp_q;
        pin_out                = out_q;
        pin_oe_n               = oen_q;
        timer_counter_clock_in = pin_fn_q[GPM_PIN_OSC_OUT];
        capture_one_in         = pin_fn_q[GPM_PIN_CAP1];
        capture_two_in         = pin_fn_q[GPM_PIN_OSC_IN];
        serial_clock_in        = pin_fn_q[GPM_PIN_SCK];
        serial_data_in         = pin_fn_q[GPM_PIN_SDI];
        transceiver_sync_clock = pin_fn_q[GPM_PIN_TX];
        transceiver_receive_in = pin_fn_q[GPM_PIN_RX];
        twi_smbus_threshold    = pin_fn_q[8];
        capture_two_on_port    = capture_two_pin_assign_q;
    end

    // The strap is treated as static; the copy only gives
    // the routing flag a registered output. Reset loads
    // the default routing onto pin one.
    // Registered copy of the channel-two assignment strap
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            capture_two_pin_assign_q <= 1'b1; // Default assignment
        end else begin
            capture_two_pin_assign_q <= capture_two_pin_assign;
        end
    end

endmodule // gpm_port

// [gpm_pkg.sv]
package gpm_pkg;

    // Register byte addresses, word aligned on the bus (address counts bytes)
    localparam logic [3:0] GPM_OFS_PIN_LEVELS   = 4'h0;  // port_pin_levels
    localparam logic [3:0] GPM_OFS_OUT_LATCH    = 4'h4;  // port_output_latch
    localparam logic [3:0] GPM_OFS_DIRECTION    = 4'h8;  // port_direction
    localparam logic [3:0] GPM_OFS_OTHER_LATCH  = 4'hC;  // other_port_latch_with_open_drain

    // Register width
    localparam int GPM_W = 8;

    // Reset values
    localparam logic [7:0] GPM_RST_DIRECTION = 8'hFF;  // All pins input
    localparam logic [7:0] GPM_RST_LATCH     = 8'h00;
    localparam logic [7:0] GPM_RST_OTHER     = 8'h00;

    // Field positions in other_port_direction_with_open_drain
    localparam int GPM_BIT_SPI_OD  = 7;  // spi_open_drain_select
    localparam int GPM_BIT_CAP2_OD = 6;  // capture_two_open_drain_select
    localparam int GPM_BIT_CAP1_OD = 5;  // capture_one_open_drain_select
    // Field positions in other_port_latch_with_open_drain
    localparam int GPM_BIT_SER2_OD = 7;  // second_transceiver_open_drain_select
    localparam int GPM_BIT_SER_OD  = 6;  // serial_transceiver_open_drain_select
    localparam logic [7:0] GPM_OTHER_LATCH_MASK = 8'hDF;  // Bit 5 unimplemented

    // Offset of other_port_direction_with_open_drain
    localparam logic [3:0] GPM_OFS_OTHER_DIR    = 4'h0;  // Placed in high window
    localparam logic [4:0] GPM_OFS_OTHER_DIR_B  = 5'h10;

    // Pin indices
    localparam int GPM_PIN_OSC_OUT = 0;
    localparam int GPM_PIN_OSC_IN  = 1;
    localparam int GPM_PIN_CAP1    = 2;
    localparam int GPM_PIN_SCK     = 3;
    localparam int GPM_PIN_SDI     = 4;
    localparam int GPM_PIN_SDO     = 5;
    localparam int GPM_PIN_TX      = 6;
    localparam int GPM_PIN_RX      = 7;

    // Serial module modes
    typedef enum logic [1:0] {
        GPM_SER_OFF,
        GPM_SER_SPI,
        GPM_SER_TWI
    } gpm_ser_mode_e;

endpackage

// [gpm_port_sva.sv]
`timescale 1ns/10ps
// Port-level checks of the pin mux and its register bus
module gpm_port_sva (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [4:0] avs_address,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic       timer_osc_enable,
    input wire logic       capture_two_pin_assign,
    input wire logic       capture_two_on_port,
    input wire logic [1:0] serial_mode,
    input wire logic       twi_sda_drive_low,
    input wire logic       twi_smbus_levels,
    input wire logic       twi_smbus_threshold,
    input wire logic       transceiver_enable,
    input wire logic       transceiver_receive_in
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Reset check runs during reset, so it opts out of the default disable
    a_reset_inputs: assert property (disable iff (1'b0) !rst_n |=> pin_oe_n == 8'hFF)
        else $error("pins not all inputs after reset");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped_resp: assert property (!avs_waitrequest && avs_address > 5'h10 |-> avs_response == 2'b10)
        else $error("unmapped address not refused");
    a_assign_copy: assert property ($past(rst_n) |-> capture_two_on_port == $past(capture_two_pin_assign))
        else $error("channel two routing wrong");
    a_osc_release: assert property (timer_osc_enable[*5] |-> pin_oe_n[1:0] == 2'b11)
        else $error("oscillator pins still driven");
    a_sda_pull: assert property ((serial_mode == 2'd2 && twi_sda_drive_low)[*5] |-> !pin_oe_n[4] && !pin_out[4])
        else $error("two-wire data not pulled low");
    a_sda_free: assert property ((serial_mode == 2'd2 && !twi_sda_drive_low)[*5] |-> pin_oe_n[4])
        else $error("two-wire data not released");
    a_smbus_thr: assert property ($stable({serial_mode, twi_smbus_levels})[*5]
        |-> twi_smbus_threshold == (serial_mode == 2'd2 && twi_smbus_levels))
        else $error("threshold select wrong");
    a_rx_follow: assert property ((transceiver_enable && $stable(pin_in[7]))[*6]
        |-> transceiver_receive_in == pin_in[7])
        else $error("receive input not following pin");
    // Main scenarios reached
    c_unmapped: cover property (!avs_waitrequest && avs_address > 5'h10);
    c_osc: cover property (timer_osc_enable[*5]);
    c_sda: cover property (serial_mode == 2'd2 && twi_sda_drive_low);
endmodule // gpm_port_sva

// [gpm_pin_model.sv]
`timescale 1ns/10ps
// Board side of the eight pins: pull-ups plus an optional external driver
module gpm_pin_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic     [7:0] pin_in
);
    // Released pin reads the external driver when enabled, else floats to the pull-up, so a stale value never reads back
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule // gpm_pin_model

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import gpm_pkg::*;
    localparam logic [4:0] A_PIN = {1'b0, GPM_OFS_PIN_LEVELS};
    localparam logic [4:0] A_LAT = {1'b0, GPM_OFS_OUT_LATCH};
    localparam logic [4:0] A_DIR = {1'b0, GPM_OFS_DIRECTION};
    localparam logic [4:0] A_ODR = GPM_OFS_OTHER_DIR_B;
    logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [1:0] avs_response, serial_mode, rs;
    logic [7:0] pin_in, pin_out, pin_oe_n, ext_en, ext_val, rd;
    logic timer_osc_enable, capture_two_pin_assign, capture_one_enable, capture_two_enable;
    logic twi_smbus_levels, transceiver_enable, transceiver_sync, transceiver_sync_master;
    logic transceiver_sync_tx, twi_scl_drive_low, twi_sda_drive_low, capture_one_out;
    logic capture_two_out, spi_clock_out, spi_data_out, transceiver_transmit_out;
    logic transceiver_sync_data_out, timer_counter_clock_in, capture_one_in, capture_two_in;
    logic serial_clock_in, serial_data_in, transceiver_receive_in, transceiver_sync_clock;
    logic twi_smbus_threshold, capture_two_on_port;
    int fails, samples_checked;
    gpm_port i_gpm_port (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .pin_in, .pin_out,
        .pin_oe_n, .timer_osc_enable, .capture_two_pin_assign, .capture_one_enable,
        .capture_two_enable, .serial_mode, .twi_smbus_levels, .transceiver_enable,
        .transceiver_sync, .transceiver_sync_master, .transceiver_sync_tx, .twi_scl_drive_low,
        .twi_sda_drive_low, .capture_one_out, .capture_two_out, .spi_clock_out, .spi_data_out,
        .transceiver_transmit_out, .transceiver_sync_data_out, .timer_counter_clock_in,
        .capture_one_in, .capture_two_in, .serial_clock_in, .serial_data_in,
        .transceiver_receive_in, .transceiver_sync_clock, .twi_smbus_threshold, .capture_two_on_port);
    gpm_pin_model i_gpm_pin_model (.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);
    // 100 ns clock
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) fails++;
        rd = avs_readdata[7:0];
        rs = avs_response;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    // Pin outputs run one clock, and pin inputs three clocks, behind their cause
    task automatic settle;
        repeat (5) @(posedge clock);
    endtask
    task automatic t_reset;
        chk("oe_n", pin_oe_n, 8'hFF);
        bus(0, A_DIR, 0); chk("dir", rd, GPM_RST_DIRECTION);
        bus(0, A_PIN, 0); chk("pins", rd, 8'hFF);
    endtask
    task automatic t_plain;
        bus(1, A_PIN, 8'hA5);
        bus(0, A_LAT, 0); chk("latch", rd, 8'hA5);
        bus(1, A_DIR, 8'h0F);
        ext_en <= 8'h0F;
        ext_val <= 8'h03;
        settle;
        chk("oe_n", pin_oe_n, 8'h0F);
        chk("out", pin_out & 8'hF0, 8'hA0);
        bus(0, A_PIN, 0); chk("pins", rd, 8'hA3);
        chk("fn_lo", {5'h0, serial_clock_in, capture_one_in, timer_counter_clock_in}, 8'h01);
        chk("fn_hi", {5'h0, transceiver_sync_clock, serial_data_in, capture_two_in}, 8'h01);
        bus(1, 5'h14, 8'hFF); chk("wresp", {6'h0, rs}, 8'h02);
        bus(0, 5'h14, 0); chk("rresp", {6'h0, rs}, 8'h02);
        chk("rdata", rd, 8'h00);
    endtask
    task automatic t_periph;
        bus(1, A_DIR, 0);
        bus(1, A_LAT, 0);
        {capture_one_enable, capture_one_out, capture_two_enable, capture_two_out} <= 4'hF;
        serial_mode <= GPM_SER_SPI;
        {spi_clock_out, spi_data_out} <= 2'b11;
        settle;
        chk("ovr", pin_out & 8'h2E, 8'h2E);
        capture_two_pin_assign <= 0;
        settle;
        chk("cap2mx", pin_out & 8'h02, 8'h00);
        chk("route", {7'h0, capture_two_on_port}, 8'h00);
        capture_two_pin_assign <= 1;
        bus(1, A_ODR, 8'h80);
        settle;
        chk("od1", pin_oe_n, 8'h28);
        {spi_clock_out, spi_data_out} <= 2'b00;
        settle;
        chk("od0", pin_oe_n, 8'h00);
        {capture_one_enable, capture_two_enable} <= 2'b00;
        serial_mode <= GPM_SER_OFF;
        settle;
        chk("back", pin_out & 8'h2E, 8'h00);
        bus(0, A_DIR, 0); chk("dir", rd, 8'h00);
    endtask
    task automatic t_osc;
        bus(1, A_DIR, 8'h80);
        {timer_osc_enable, transceiver_enable, transceiver_transmit_out} <= 3'b111;
        ext_en <= 8'h80;
        ext_val <= 8'h00;
        settle;
        chk("osc", pin_oe_n & 8'h03, 8'h03);
        chk("tx", pin_out & 8'h40, 8'h40);
        chk("rx0", {7'h0, transceiver_receive_in}, 8'h00);
        bus(0, A_DIR, 0); chk("dir", rd, 8'h80);
        ext_val <= 8'h80;
        settle;
        chk("rx1", {7'h0, transceiver_receive_in}, 8'h01);
        timer_osc_enable <= 0;
    endtask
    task automatic t_twi;
        serial_mode <= GPM_SER_TWI;
        {twi_smbus_levels, twi_scl_drive_low, twi_sda_drive_low} <= 3'b111;
        settle;
        chk("low", (pin_oe_n | pin_out) & 8'h18, 8'h00);
        chk("thr", {7'h0, twi_smbus_threshold}, 8'h01);
        {twi_scl_drive_low, twi_sda_drive_low} <= 2'b00;
        settle;
        chk("free", pin_oe_n & 8'h18, 8'h18);
    endtask
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {avs_read, avs_write, timer_osc_enable, capture_one_enable, capture_two_enable} = '0;
        {twi_smbus_levels, transceiver_enable, transceiver_sync, transceiver_sync_master} = '0;
        {transceiver_sync_tx, twi_scl_drive_low, twi_sda_drive_low, capture_one_out} = '0;
        {capture_two_out, spi_clock_out, spi_data_out, transceiver_transmit_out} = '0;
        {transceiver_sync_data_out, fails, samples_checked, avs_address, avs_writedata} = '0;
        {serial_mode, ext_en, ext_val} = '0;
        capture_two_pin_assign = 1;
        avs_byteenable = 4'h1;
        rst_n = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1;
        t_reset;
        t_plain;
        t_periph;
        t_osc;
        t_twi;
        summarize;
    end
    // Watchdog, far beyond the hundred or so cycles the tests take
    initial begin
        #2000000;
        fails++;
        summarize;
    end
endmodule // tb_top
bind gpm_port gpm_port_sva i_gpm_port_sva (.clock, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_waitrequest, .avs_response, .pin_in, .pin_out, .pin_oe_n, .timer_osc_enable,
    .capture_two_pin_assign, .capture_two_on_port, .serial_mode, .twi_sda_drive_low,
    .twi_smbus_levels, .twi_smbus_threshold, .transceiver_enable, .transceiver_receive_in);
